// [design/ddcf_pkg.sv]
// constants for the final half-band, gain and complex-to-real stage
package ddcf_pkg;

    // ======================================================
    // widths and counts
    localparam int DDC_N = 2;
    localparam int SAMP_W = 16;
    localparam int ACC_W = 44;
    localparam int ADR_W = 14;
    localparam int IDX_W = 12;
    localparam int CFG_W = 8;

    // ======================================================
    // final half-band filter: 55 taps, 21-bit signed coefficients
    localparam int FHB_TAPS = 55;
    localparam int FHB_MID = 27;
    localparam int FHB_PAIRS = 14;
    localparam int FHB_FRAC = 20;
    localparam logic signed [20:0] FHB_CENTRE = 21'sd524288;
    // odd-numbered mirrored pairs, outermost first
    localparam logic signed [20:0] FHB_COEF [FHB_PAIRS] = '{
        -21'sd24, 21'sd102, -21'sd302, 21'sd730, -21'sd1544, 21'sd2964, -21'sd5284,
        21'sd8903, -21'sd14383, 21'sd22640, -21'sd35476, 21'sd57468, -21'sd105442, 21'sd331792
    };

    // ======================================================
    // register map: index of each register, byte address is four times it
    localparam int REG_N = 14;
    localparam int SLOT_NONE = 15;
    localparam int SLOT_CHIP_CFG = 0;
    localparam int SLOT_CHIP_DEC = 1;
    localparam int SLOT_DDC_BASE = 2;
    localparam int SLOTS_PER_DDC = 6;
    // per-ddc slot offsets: control, input select, tuning lo/hi, phase lo/hi
    localparam int OFS_CTRL = 0;
    localparam int OFS_INSEL = 1;
    localparam int OFS_FTW_LO = 2;
    localparam int OFS_FTW_HI = 3;
    localparam int OFS_POW_LO = 4;
    localparam int OFS_POW_HI = 5;
    localparam logic [11:0] REG_INDEX [REG_N] = '{
        12'h200, 12'h201,                                   // ddc_count_iq_select, chip_decimation_ratio
        12'h310, 12'h311, 12'h314, 12'h315, 12'h320, 12'h321, // ddc0 control .. phase high
        12'h330, 12'h331, 12'h334, 12'h335, 12'h340, 12'h341  // ddc1 control .. phase high
    };
    localparam logic [7:0] REG_RESET [REG_N] = '{
        8'h01, 8'h01,
        8'h83, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h83, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00
    };

    // ======================================================
    // field positions
    localparam int CHIP_NDDC_LSB = 0;
    localparam int CHIP_IONLY_BIT = 5;
    localparam logic [1:0] NDDC_ONE = 2'h1;
    localparam logic [1:0] NDDC_TWO = 2'h2;
    localparam int CTRL_MIX_CPLX_BIT = 7;
    localparam int CTRL_GAIN6_BIT = 6;
    localparam int CTRL_C2R_BIT = 3;
    localparam int CTRL_FILT_LSB = 0;
    localparam logic [1:0] FILT_FINAL_ONLY = 2'h3;
    localparam int INSEL_I_B_BIT = 0;
    localparam int INSEL_Q_B_BIT = 2;

endpackage : ddcf_pkg

// [design/ddcf_top.sv]
// final half-band, gain and complex-to-real stage of both downconverters
//
// Contract
// - final stage is 55-tap half-band, decimate two
// - final half-band filter can never be bypassed
// - fixed 21-bit coefficients, zero even pairs
// - per-converter gain select, 0 dB or 6 dB
// - complex-to-real skips the rate halving
// - complex-to-real reuses filter, quarter-rate upmix
// - quadrature product dropped, in-phase output only
// - ddc_count_iq_select selects converter count and I-only
// - chip_decimation_ratio selects chip decimation two or four
// - 0x83 complex, 0 dB, final filter only
// - 0x80 complex, 0 dB, third plus final
// - 0x48 real mixer, 6 dB, real output
// - 0x4B 6 dB, real output, final only
// - input select routes ADC A/B to I/Q
// - second converter registers at ddc1_control, ddc1_input_select
// - tuning and phase words at fixed registers
// - third half-band only for decimation four up; enable follows the control filter field, not chip decimation
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps

module ddcf_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ddcf_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // adc core samples and routed copies towards the mixer
    input wire logic [ddcf_pkg::SAMP_W-1:0] adc_a_i,
    input wire logic [ddcf_pkg::SAMP_W-1:0] adc_b_i,
    input wire logic adc_valid_i,
    output logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] route_i_o,
    output logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] route_q_o,
    output logic [ddcf_pkg::DDC_N-1:0] route_valid_o,
    // configuration towards the mixer and earlier filters
    output logic [ddcf_pkg::DDC_N-1:0][15:0] frequency_tuning_word_o,
    output logic [ddcf_pkg::DDC_N-1:0][15:0] phase_offset_word_o,
    output logic [ddcf_pkg::DDC_N-1:0] mix_complex_o,
    output logic [ddcf_pkg::DDC_N-1:0] third_halfband_filter_en_o,
    output logic [ddcf_pkg::CFG_W-1:0] chip_decimation_o,
    // baseband samples from the mixer and earlier filters
    input wire logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] bb_i_i,
    input wire logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] bb_q_i,
    input wire logic [ddcf_pkg::DDC_N-1:0] bb_valid_i,
    // filtered output samples
    output logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] out_i_o,
    output logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] out_q_o,
    output logic [ddcf_pkg::DDC_N-1:0] out_valid_o
);
    import ddcf_pkg::*;

    // ======================================================
    // helpers

    // map a register index to its storage slot, SLOT_NONE when unmapped
    function automatic logic [3:0] reg_slot(input logic [IDX_W-1:0] idx);
        logic [3:0] s;
        s = 4'(SLOT_NONE);
        for (int k = 0; k < REG_N; k++) begin
            if (REG_INDEX[k] == idx) begin
                s = 4'(k);
            end
        end
        return s;
    endfunction : reg_slot

    // clamp a wide value to the signed sample range
    function automatic logic signed [SAMP_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
        logic signed [SAMP_W-1:0] r;
        r = v[SAMP_W-1:0];
        if (v > ACC_W'(32767)) begin
            r = 16'sh7fff;
        end else if (v < -ACC_W'(32768)) begin
            r = 16'sh8000;
        end
        return r;
    endfunction : sat16

    // symmetric half-band: fold mirrored taps, skip the zero pairs
    function automatic logic signed [ACC_W-1:0] fhb_sum(input logic signed [SAMP_W-1:0] t [FHB_TAPS]);
        logic signed [ACC_W-1:0] acc;
        logic signed [SAMP_W:0] pair;
        acc = ACC_W'(t[FHB_MID]) * ACC_W'(FHB_CENTRE);
        for (int k = 0; k < FHB_PAIRS; k++) begin
            pair = (SAMP_W+1)'(t[2*k]) + (SAMP_W+1)'(t[FHB_TAPS-1-2*k]);
            acc = acc + ACC_W'(pair) * ACC_W'(FHB_COEF[k]);
        end
        return acc;
    endfunction : fhb_sum

    // ======================================================
    // wishbone slave: one wait state, ack for one cycle

    logic [CFG_W-1:0] cfg_reg [REG_N];
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [3:0] slot;

    assign slot = reg_slot(wb_adr_i[ADR_W-1:2]);
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // ack drops the cycle after it was given, so back-to-back needs a gap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end

    // read data; unmapped indexes read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            rdata_reg <= 32'h0000_0000;
            if (slot != 4'(SLOT_NONE)) begin
                rdata_reg <= {24'h00_0000, cfg_reg[slot]};
            end
        end
    end

    // writes land on the acknowledging edge, low byte lane only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int k = 0; k < REG_N; k++) begin
                cfg_reg[k] <= REG_RESET[k];
            end
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0]) begin
            if (slot != 4'(SLOT_NONE)) begin
                cfg_reg[slot] <= wb_dat_i[CFG_W-1:0];
            end
        end
    end

    // chip decimation is passed on to the output framing
    assign chip_decimation_o = cfg_reg[SLOT_CHIP_DEC];

    // ======================================================
    // per-converter datapath

    logic [1:0] ndd;
    logic i_only;
    assign ndd = cfg_reg[SLOT_CHIP_CFG][CHIP_NDDC_LSB +: 2];
    assign i_only = cfg_reg[SLOT_CHIP_CFG][CHIP_IONLY_BIT];

    for (genvar d = 0; d < DDC_N; d++) begin : g_ddc
        localparam int B = SLOT_DDC_BASE + d * SLOTS_PER_DDC;

        logic signed [SAMP_W-1:0] tap_i_reg [FHB_TAPS];
        logic signed [SAMP_W-1:0] tap_q_reg [FHB_TAPS];
        logic [CFG_W-1:0] act_ctrl_reg;
        logic dec_phase_reg;
        logic fire_reg;
        logic filt_valid_reg;
        logic signed [SAMP_W-1:0] filt_i_reg;
        logic signed [SAMP_W-1:0] filt_q_reg;
        logic [1:0] c2r_phase_reg;
        logic [SAMP_W-1:0] out_i_reg;
        logic [SAMP_W-1:0] out_q_reg;
        logic out_valid_reg;
        logic [SAMP_W-1:0] rt_i_reg;
        logic [SAMP_W-1:0] rt_q_reg;
        logic rt_valid_reg;
        logic enabled;
        logic c2r;
        logic gain6;
        logic signed [SAMP_W-1:0] fi;
        logic signed [SAMP_W-1:0] fq;
        logic signed [SAMP_W-1:0] real_out;

        // second converter runs only when two are selected
        assign enabled = (d == 0) ? (ndd != 2'h0) : (ndd == NDDC_TWO);
        assign c2r = act_ctrl_reg[CTRL_C2R_BIT];
        assign gain6 = act_ctrl_reg[CTRL_GAIN6_BIT];

        // settings towards the mixer and earlier stages
        assign frequency_tuning_word_o[d] = {cfg_reg[B+OFS_FTW_HI], cfg_reg[B+OFS_FTW_LO]};
        assign phase_offset_word_o[d] = {cfg_reg[B+OFS_POW_HI], cfg_reg[B+OFS_POW_LO]};
        assign mix_complex_o[d] = act_ctrl_reg[CTRL_MIX_CPLX_BIT];
        // 11 is final filter only (decimate 2), anything else adds the third
        assign third_halfband_filter_en_o[d] =
            act_ctrl_reg[CTRL_FILT_LSB +: 2] != FILT_FINAL_ONLY;

        // input routing: bit set picks channel b for that path
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                rt_i_reg <= 16'h0000;
                rt_q_reg <= 16'h0000;
                rt_valid_reg <= 1'b0;
            end else begin
                rt_valid_reg <= adc_valid_i && enabled;
                if (adc_valid_i) begin
                    rt_i_reg <= cfg_reg[B+OFS_INSEL][INSEL_I_B_BIT] ? adc_b_i : adc_a_i;
                    rt_q_reg <= cfg_reg[B+OFS_INSEL][INSEL_Q_B_BIT] ? adc_b_i : adc_a_i;
                end
            end
        end
        assign route_i_o[d] = rt_i_reg;
        assign route_q_o[d] = rt_q_reg;
        assign route_valid_o[d] = rt_valid_reg;

        // control is copied at a sample so a mode never changes mid-sample
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                act_ctrl_reg <= REG_RESET[B+OFS_CTRL];
            end else if (bb_valid_i[d]) begin
                act_ctrl_reg <= cfg_reg[B+OFS_CTRL];
            end
        end

        // delay line; the filter is always in the path, no bypass
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                for (int k = 0; k < FHB_TAPS; k++) begin
                    tap_i_reg[k] <= 16'sh0000;
                    tap_q_reg[k] <= 16'sh0000;
                end
            end else if (bb_valid_i[d] && enabled) begin
                tap_i_reg[0] <= bb_i_i[d];
                tap_q_reg[0] <= bb_q_i[d];
                for (int k = 1; k < FHB_TAPS; k++) begin
                    tap_i_reg[k] <= tap_i_reg[k-1];
                    tap_q_reg[k] <= tap_q_reg[k-1];
                end
            end
        end

        // keep every second result, or every one in complex-to-real mode
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                dec_phase_reg <= 1'b0;
                fire_reg <= 1'b0;
            end else begin
                fire_reg <= bb_valid_i[d] && enabled && (c2r || dec_phase_reg);
                if (bb_valid_i[d] && enabled) begin
                    dec_phase_reg <= !dec_phase_reg;
                end
            end
        end

        // filter sum, rescale and gain in one stage
        assign fi = sat16(fhb_sum(tap_i_reg) >>> FHB_FRAC);
        assign fq = sat16(fhb_sum(tap_q_reg) >>> FHB_FRAC);
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                filt_i_reg <= 16'sh0000;
                filt_q_reg <= 16'sh0000;
                filt_valid_reg <= 1'b0;
            end else begin
                filt_valid_reg <= fire_reg;
                if (fire_reg) begin
                    // shift saturates rather than wraps, clipping instead of sign flips
                    filt_i_reg <= gain6 ? sat16(ACC_W'(fi) <<< 1) : fi;
                    filt_q_reg <= gain6 ? sat16(ACC_W'(fq) <<< 1) : fq;
                end
            end
        end

        // quarter-rate upmix, real part: i, -q, -i, q
        always_comb begin
            case (c2r_phase_reg)
                2'h0: real_out = filt_i_reg;
                2'h1: real_out = sat16(-ACC_W'(filt_q_reg));
                2'h2: real_out = sat16(-ACC_W'(filt_i_reg));
                2'h3: real_out = filt_q_reg;
                default: real_out = filt_i_reg;
            endcase
        end

        // output register; q is zero in real or i-only modes
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                c2r_phase_reg <= 2'h0;
                out_i_reg <= 16'h0000;
                out_q_reg <= 16'h0000;
                out_valid_reg <= 1'b0;
            end else begin
                out_valid_reg <= filt_valid_reg;
                if (filt_valid_reg) begin
                    if (c2r) begin
                        c2r_phase_reg <= c2r_phase_reg + 2'h1;
                        out_i_reg <= real_out;
                        out_q_reg <= 16'h0000;
                    end else begin
                        c2r_phase_reg <= 2'h0;
                        out_i_reg <= filt_i_reg;
                        out_q_reg <= i_only ? 16'h0000 : filt_q_reg;
                    end
                end
            end
        end
        assign out_i_o[d] = out_i_reg;
        assign out_q_o[d] = out_q_reg;
        assign out_valid_o[d] = out_valid_reg;
    end

endmodule : ddcf_top

// [sim/ddcf_props.sv]
// assertion checker for the downconverter final stage, bound to its top
`timescale 1ns/1ps
// =============================================
// port-level checker
module ddcf_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [ddcf_pkg::SAMP_W-1:0] adc_a_i,
    input wire logic [ddcf_pkg::SAMP_W-1:0] adc_b_i,
    input wire logic adc_valid_i,
    input wire logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] route_i_o,
    input wire logic [ddcf_pkg::DDC_N-1:0] route_valid_o,
    input wire logic [ddcf_pkg::DDC_N-1:0][15:0] frequency_tuning_word_o,
    input wire logic [ddcf_pkg::DDC_N-1:0] mix_complex_o,
    input wire logic [ddcf_pkg::DDC_N-1:0] third_halfband_filter_en_o,
    input wire logic [ddcf_pkg::CFG_W-1:0] chip_decimation_o,
    input wire logic [ddcf_pkg::DDC_N-1:0] bb_valid_i,
    input wire logic [ddcf_pkg::DDC_N-1:0] out_valid_o
);
    import ddcf_pkg::*;
    // one clock domain, so reset masks every check at once
    default clocking cb @(posedge clk_i);
    endclocking
    // reset is released by a non-blocking write on an edge, so checks wait one more
    // edge; otherwise $past and $changed would compare against pre-reset values
    logic rst_hold_reg;
    always_ff @(posedge clk_i) begin
        rst_hold_reg <= rst_i;
    end
    default disable iff (rst_i || rst_hold_reg);
    // a taken request is answered on the next edge, for one cycle only
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_one_ack;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    bus_ack_pulse_a: assert property (s_taken |-> s_one_ack)
        else $error("bus answer late or held");
    byte_lane_only_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above low byte");
    out_cause_a: assert property ((out_valid_o & ~$past(bb_valid_i, 3)) == '0)
        else $error("output without a sample three cycles back");
    route_timing_a: assert property (route_valid_o[0] == $past(adc_valid_i))
        else $error("routed sample off by a cycle");
    route_source_a: assert property (route_valid_o[0] |->
        route_i_o[0] == $past(adc_a_i) || route_i_o[0] == $past(adc_b_i))
        else $error("routed sample from neither channel");
    tuning_on_write_a: assert property ($changed(frequency_tuning_word_o) |-> $past(wb_ack_o))
        else $error("tuning word moved without a write");
    decim_on_write_a: assert property ($changed(chip_decimation_o) |-> $past(wb_ack_o))
        else $error("decimation moved without a write");
    // control copy may only move at a sample boundary
    ctrl_at_sample_a: assert property ($changed({mix_complex_o[0], third_halfband_filter_en_o[0]}) |->
        $past(bb_valid_i[0]))
        else $error("control applied between samples");
endmodule : ddcf_checker

bind ddcf_top ddcf_checker u_ddcf_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
    .adc_a_i, .adc_b_i, .adc_valid_i, .route_i_o, .route_valid_o, .frequency_tuning_word_o,
    .mix_complex_o, .third_halfband_filter_en_o, .chip_decimation_o, .bb_valid_i, .out_valid_o);

// [sim/ddcf_stream_model.sv]
// stand-in for the adc cores and the mixer path feeding the final stage
`timescale 1ns/1ps
// =============================================
// sample source
module ddcf_stream_model (
    input wire logic clk_i,
    output logic [ddcf_pkg::SAMP_W-1:0] adc_a_o,
    output logic [ddcf_pkg::SAMP_W-1:0] adc_b_o,
    output logic adc_valid_o,
    output logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] bb_i_o,
    output logic [ddcf_pkg::DDC_N-1:0][ddcf_pkg::SAMP_W-1:0] bb_q_o,
    output logic [ddcf_pkg::DDC_N-1:0] bb_valid_o
);
    import ddcf_pkg::*;
    // quiet lines from time zero
    initial begin
        adc_a_o = '0;
        adc_b_o = '0;
        adc_valid_o = 1'b0;
        bb_i_o = '0;
        bb_q_o = '0;
        bb_valid_o = '0;
    end
    // one adc sample; afterwards stale data is inverted so nothing relies on it
    task automatic adc_sample(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk_i);
        adc_a_o <= a;
        adc_b_o <= b;
        adc_valid_o <= 1'b1;
        @(posedge clk_i);
        adc_valid_o <= 1'b0;
        adc_a_o <= ~a;
        adc_b_o <= ~b;
    endtask : adc_sample
    // n back-to-back baseband samples on one converter
    task automatic bb_run(input int d, input logic [15:0] si, input logic [15:0] sq, input int n);
        repeat (n) begin
            @(posedge clk_i);
            bb_i_o[d] <= si;
            bb_q_o[d] <= sq;
            bb_valid_o[d] <= 1'b1;
        end
        @(posedge clk_i);
        bb_valid_o[d] <= 1'b0;
        bb_i_o[d] <= ~si;
        bb_q_o[d] <= ~sq;
    endtask : bb_run
endmodule : ddcf_stream_model

// [sim/testbench.sv]
// self-checking bench for the downconverter final stage
`timescale 1ns/1ps
// =============================================
// bench top
module testbench;
    import ddcf_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [13:0] wb_adr_i = 14'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [15:0] adc_a_i, adc_b_i;
    logic adc_valid_i;
    logic [DDC_N-1:0][SAMP_W-1:0] route_i_o, route_q_o, out_i_o, out_q_o, bb_i_i, bb_q_i;
    logic [DDC_N-1:0][15:0] frequency_tuning_word_o, phase_offset_word_o;
    logic [DDC_N-1:0] route_valid_o, mix_complex_o, third_halfband_filter_en_o, out_valid_o, bb_valid_i;
    logic [7:0] chip_decimation_o;
    logic [15:0] qi[$], qq[$], q1;
    int error_cnt = 0, n_compared = 0, n1 = 0, i;
    longint p;
    logic [7:0] codes [4] = '{8'h83, 8'h80, 8'h48, 8'h4B};
    logic [7:0] insel [3] = '{8'h04, 8'h00, 8'h05};
    logic [15:0] gin [3] = '{16'h7FFF, 16'h8000, 16'h2000};
    logic [15:0] gex [3] = '{16'h7FFF, 16'h8000, 16'h4000};
    logic [15:0] cex [4] = '{16'h4000, 16'hE000, 16'hC000, 16'h2000};

    ddcf_top u_ddcf_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_dat_o, .wb_ack_o, .adc_a_i, .adc_b_i, .adc_valid_i, .route_i_o, .route_q_o, .route_valid_o,
        .frequency_tuning_word_o, .phase_offset_word_o, .mix_complex_o, .third_halfband_filter_en_o,
        .chip_decimation_o, .bb_i_i, .bb_q_i, .bb_valid_i, .out_i_o, .out_q_o, .out_valid_o);
    ddcf_stream_model u_ddcf_stream_model (.clk_i, .adc_a_o(adc_a_i), .adc_b_o(adc_b_i),
        .adc_valid_o(adc_valid_i), .bb_i_o(bb_i_i), .bb_q_o(bb_q_i), .bb_valid_o(bb_valid_i));

    // =============================================
    // clock and output capture
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // every converter 0 output pulse is kept and converter 1 pulses are counted, so counts show the rate change
    always @(posedge clk_i) begin
        if (out_valid_o[0] === 1'b1) begin
            qi.push_back(out_i_o[0]);
            qq.push_back(out_q_o[0]);
        end
        if (out_valid_o[1] === 1'b1) begin
            n1++;
            q1 = out_q_o[1];
        end
    end

    // =============================================
    // tasks
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // classic cycle: hold the request until ack is sampled, then release
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
        bit got;
        got = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {a, 2'b00};
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        for (int k = 0; k < 20 && !got; k++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) begin
                got = 1;
                r = wb_dat_o;
            end
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (!got) begin
            error_cnt++;
            end_of_test();
        end
    endtask : wb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        wb(1'b0, a, 8'h0, x);
        chk(x, e);
    endtask : rc

    // =============================================
    // scenarios
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < REG_N; i++) rc(REG_INDEX[i], {24'h0, REG_RESET[i]});
        rc(12'h3FF, 32'h0);
        wr(12'h334, 8'hA5);
        wr(12'h335, 8'h5A);
        wr(12'h340, 8'h3C);
        wr(12'h341, 8'hC3);
        // the last write lands on the edge the task returns at
        @(posedge clk_i);
        chk(frequency_tuning_word_o[1], 32'h5AA5);
        chk(phase_offset_word_o[1], 32'hC33C);
        wr(12'h201, 8'h02);
        @(posedge clk_i);
        chk(chip_decimation_o, 32'h02);
        // the three documented input selections
        for (i = 0; i < 3; i++) begin
            wr(12'h311, insel[i]);
            u_ddcf_stream_model.adc_sample(16'h1234, 16'hBEEF);
            @(posedge clk_i);
            chk(route_i_o[0], i == 2 ? 16'hBEEF : 16'h1234);
            chk(route_q_o[0], i == 1 ? 16'h1234 : 16'hBEEF);
        end
        // control codes take effect at the next sample
        for (i = 0; i < 4; i++) begin
            wr(12'h310, codes[i]);
            u_ddcf_stream_model.bb_run(0, 16'h0, 16'h0, 1);
            @(posedge clk_i);
            chk(mix_complex_o[0], i < 2);
            chk(third_halfband_filter_en_o[0], i == 1 || i == 2);
        end
        // impulse after a mid-run reset: outputs step through the odd pairs
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // outputs from the control-code samples must not count here
        qi.delete();
        qq.delete();
        u_ddcf_stream_model.bb_run(0, 16'h0, 16'h0, 1);
        u_ddcf_stream_model.bb_run(0, 16'h4000, 16'h4000, 1);
        u_ddcf_stream_model.bb_run(0, 16'h0, 16'h0, 26);
        repeat (6) @(posedge clk_i);
        chk(qi.size(), 14);
        for (i = 0; i < 14; i++) begin
            p = (longint'(FHB_COEF[i]) * 16384) >>> 20;
            chk(qi[i], p[15:0]);
            chk(qq[i], p[15:0]);
        end
        // second converter only runs once two are selected, then I only
        u_ddcf_stream_model.bb_run(1, 16'h4000, 16'h4000, 4);
        wr(12'h200, 8'h22);
        u_ddcf_stream_model.bb_run(1, 16'h4000, 16'h4000, 4);
        repeat (6) @(posedge clk_i);
        chk(n1, 2);
        chk(q1, 16'h0);
        // gain doubling saturates at both rails
        wr(12'h310, 8'hC3);
        for (i = 0; i < 3; i++) begin
            u_ddcf_stream_model.bb_run(0, gin[i], gin[i], 60);
            repeat (6) @(posedge clk_i);
            chk(qi[$], gex[i]);
        end
        // complex-to-real: every sample out, quarter-rate rotation, Q dropped
        wr(12'h310, 8'h83);
        u_ddcf_stream_model.bb_run(0, 16'h4000, 16'h2000, 60);
        repeat (6) @(posedge clk_i);
        qi.delete();
        qq.delete();
        wr(12'h310, 8'h0B);
        // first sample still runs under the old decimating copy and makes no output
        u_ddcf_stream_model.bb_run(0, 16'h4000, 16'h2000, 5);
        repeat (6) @(posedge clk_i);
        chk(qi.size(), 4);
        for (i = 0; i < 4; i++) begin
            chk(qi[i], cex[i]);
            chk(qq[i], 16'h0);
        end
        end_of_test();
    end
endmodule : testbench
